// >>> edge_catch.sv
`timescale 1ns/10ps
// registers one pin and flags its edges
module edge_catch #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic prev_reg;  // level one cycle older

  // two stages give a clean edge compare
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      level    <= RST_VAL;
      prev_reg <= RST_VAL;
    end else begin
      level    <= din;
      prev_reg <= level;
    end
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;

endmodule : edge_catch

// >>> spi_cfg_defines.svh
`ifndef SPI_CFG_DEFINES_SVH
`define SPI_CFG_DEFINES_SVH

// register byte addresses on the serial bus
`define ADDR_IF_CFG      15'h0000
`define ADDR_MODE_CFG    15'h0002
`define ADDR_DEV_CLASS   15'h0003
`define ADDR_PART_LO     15'h0004
`define ADDR_PART_HI     15'h0005
`define ADDR_MAKER_LO    15'h000c
`define ADDR_MAKER_HI    15'h000d
`define ADDR_USER_CFG    15'h0010

// interface_config fields
`define IF_SOFT_RST_BIT  7
`define IF_ASCEND_BIT    5
`define IF_SEP_OUT_BIT   4
`define IF_CFG_RESET     8'h30

// operating_mode_config fields
`define MODE_LSB         0
`define MODE_MSB         1
`define MODE_CFG_RESET   8'h00
`define MODE_NORMAL      2'h0
`define MODE_POWER_DOWN  2'h3

// device_class upper reserved nibble and user config
`define CLASS_HI_RESET   4'h0
`define USER_FREEZE_BIT  0
`define USER_CFG_RESET   8'h00

// frame layout: one direction bit, fifteen address bits, then data
`define HDR_BITS         5'h10
`define BYTE_LAST_BIT    3'h7

// soft reset quiet period
`define SOFT_RST_NS      750
`define MCLK_PERIOD_NS   10
`define SOFT_RST_CYCLES  ((`SOFT_RST_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// >>> spi_cfg_pkg.sv
package spi_cfg_pkg;

  // serial bus pins seen by the device
  typedef struct packed {
    logic sclk;  // serial clock from the host
    logic cs_n;  // chip select, active low
    logic sdi;   // serial data in
  } spi_in_s;

  // frame sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_HDR  = 4'h2,
    ST_DATA = 4'h4,
    ST_RST  = 4'h8
  } frame_state_e;

endpackage : spi_cfg_pkg

// >>> spi_config_id_registers.sv
// Summary of operation
// - soft-reset bit resets chip and all registers
// - soft-reset bit clears itself after reset
// - direction bit picks streaming address step
// - output-line flag reads one; reads on sdo
// - mode field: normal or power down
// - device-class nibble is fixed read-only code
// - part identifier is fixed 16-bit code
// - maker identifier is fixed 16-bit code
// - freeze bit holds streaming address constant
`timescale 1ns/10ps
`include "spi_cfg_defines.svh"
module spi_config_id_registers #(
  parameter logic [3:0]  DEV_CLASS = 4'ha,     // arbitrary value
  parameter logic [15:0] PART_ID   = 16'h5a3c, // arbitrary value
  parameter logic [15:0] MAKER_ID  = 16'h1e7b  // arbitrary value
) (
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire spi_cfg_pkg::spi_in_s spi_in,
  output logic                      sdo,
  output logic                      sdo_oe,
  output logic                      chip_reset,
  output logic [1:0]                op_mode,
  output logic                      power_down
);

  localparam logic [6:0] RST_CYCLES = 7'(`SOFT_RST_CYCLES);

  spi_cfg_pkg::frame_state_e state_reg;  // frame sequencer
  logic        sclk_rise;                // sampling edge
  logic        sclk_fall;                // shifting edge
  logic        cs_level;                 // registered select
  logic        cs_fall;                  // frame start
  logic        sdi_q;                    // data bit aligned to edges
  logic [4:0]  bit_cnt_reg;              // bits in header or byte
  logic [14:0] hdr_sr_reg;               // header shift register
  logic        rd_reg;                   // frame is a read
  logic [14:0] addr_reg;                 // current register address
  logic [6:0]  rx_sr_reg;                // write data shift register
  logic [7:0]  tx_sr_reg;                // read data shift register
  logic        load_reg;                 // reload tx after the header or a byte
  logic [6:0]  rst_cnt_reg;              // quiet period counter
  logic [7:0]  if_cfg_reg;               // interface_config
  logic [7:0]  mode_cfg_reg;             // operating_mode_config
  logic [3:0]  class_hi_reg;             // device_class writable nibble
  logic [7:0]  user_cfg_reg;             // user configuration
  logic        hdr_done;                 // last header bit sampled
  logic        byte_done;                // last data bit sampled
  logic        wr_en;                    // commit a written byte
  logic [7:0]  wr_data;                  // byte being committed
  logic        soft_clr;                 // soft reset request
  logic [14:0] addr_next;                // streaming next address

  // pin registers with edge flags; pins are synchronous to mclk
  edge_catch #(.RST_VAL(1'b0)) u_sclk (
    .mclk  (mclk),
    .nrst  (nrst),
    .din   (spi_in.sclk),
    .level (),
    .rise  (sclk_rise),
    .fall  (sclk_fall)
  );
  edge_catch #(.RST_VAL(1'b1)) u_cs (
    .mclk  (mclk),
    .nrst  (nrst),
    .din   (spi_in.cs_n),
    .level (cs_level),
    .rise  (),
    .fall  (cs_fall)
  );
  edge_catch #(.RST_VAL(1'b0)) u_sdi (
    .mclk  (mclk),
    .nrst  (nrst),
    .din   (spi_in.sdi),
    .level (sdi_q),
    .rise  (),
    .fall  ()
  );

  // read mux over the byte map; unmapped addresses read zero
  function automatic logic [7:0] rd_byte(input logic [14:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `ADDR_IF_CFG:    v = if_cfg_reg | (8'h01 << `IF_SEP_OUT_BIT);
      `ADDR_MODE_CFG:  v = mode_cfg_reg;
      `ADDR_DEV_CLASS: v = {class_hi_reg, DEV_CLASS};
      `ADDR_PART_LO:   v = PART_ID[7:0];
      `ADDR_PART_HI:   v = PART_ID[15:8];
      `ADDR_MAKER_LO:  v = MAKER_ID[7:0];
      `ADDR_MAKER_HI:  v = MAKER_ID[15:8];
      `ADDR_USER_CFG:  v = user_cfg_reg;
      default:         v = 8'h00;
    endcase
    return v;
  endfunction : rd_byte

  assign hdr_done  = (state_reg == spi_cfg_pkg::ST_HDR) && sclk_rise &&
                     (bit_cnt_reg == `HDR_BITS - 5'h01);
  assign byte_done = (state_reg == spi_cfg_pkg::ST_DATA) && sclk_rise &&
                     (bit_cnt_reg[2:0] == `BYTE_LAST_BIT);
  assign wr_en     = byte_done && !rd_reg;
  assign wr_data   = {rx_sr_reg, sdi_q};
  assign soft_clr  = wr_en && (addr_reg == `ADDR_IF_CFG) &&
                     wr_data[`IF_SOFT_RST_BIT];

  always_comb begin
    if (user_cfg_reg[`USER_FREEZE_BIT]) begin
      addr_next = addr_reg;
    end else if (if_cfg_reg[`IF_ASCEND_BIT]) begin
      addr_next = addr_reg + 15'h0001;
    end else begin
      addr_next = addr_reg - 15'h0001;
    end
  end

  // frame sequencer; a deselect always ends the frame
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= spi_cfg_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        spi_cfg_pkg::ST_IDLE: begin
          // only a fresh select edge starts a frame
          if (cs_fall) begin
            state_reg <= spi_cfg_pkg::ST_HDR;
          end
        end
        spi_cfg_pkg::ST_HDR: begin
          if (cs_level) begin
            state_reg <= spi_cfg_pkg::ST_IDLE;
          end else if (hdr_done) begin
            state_reg <= spi_cfg_pkg::ST_DATA;
          end
        end
        spi_cfg_pkg::ST_DATA: begin
          if (soft_clr) begin
            state_reg <= spi_cfg_pkg::ST_RST;
          end else if (cs_level) begin
            state_reg <= spi_cfg_pkg::ST_IDLE;
          end
        end
        spi_cfg_pkg::ST_RST: begin
          if (rst_cnt_reg == 7'h01) begin
            state_reg <= spi_cfg_pkg::ST_IDLE;
          end
        end
        default: state_reg <= spi_cfg_pkg::ST_IDLE;
      endcase
    end
  end

  // header and data bit counting and shifting in
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_reg <= 5'h00;
      hdr_sr_reg  <= 15'h0000;
      rx_sr_reg   <= 7'h00;
      rd_reg      <= 1'b0;
      addr_reg    <= 15'h0000;
    end else if (state_reg == spi_cfg_pkg::ST_IDLE) begin
      bit_cnt_reg <= 5'h00;
    end else if (hdr_done) begin
      // first bit is the direction, then the address msb first
      rd_reg      <= hdr_sr_reg[14];
      addr_reg    <= {hdr_sr_reg[13:0], sdi_q};
      bit_cnt_reg <= 5'h00;
    end else if (byte_done) begin
      addr_reg    <= addr_next;
      bit_cnt_reg <= 5'h00;
    end else if (sclk_rise) begin
      hdr_sr_reg  <= {hdr_sr_reg[13:0], sdi_q};
      rx_sr_reg   <= {rx_sr_reg[5:0], sdi_q};
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // read data shifts out msb first on the falling edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_sr_reg <= 8'h00;
      load_reg  <= 1'b0;
    end else begin
      load_reg <= hdr_done || byte_done;
      if (load_reg) begin
        tx_sr_reg <= rd_byte(addr_reg);
      end else if (sclk_fall && state_reg == spi_cfg_pkg::ST_DATA &&
                   bit_cnt_reg != 5'h00) begin
        tx_sr_reg <= {tx_sr_reg[6:0], 1'b0};
      end
    end
  end

  // reads only on the dedicated output line
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo    <= tx_sr_reg[7];
      sdo_oe <= (state_reg == spi_cfg_pkg::ST_DATA) && rd_reg && !cs_level;
    end
  end

  // register bank; fixed identity codes have no storage, the output-line flag is stored as one
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      if_cfg_reg   <= `IF_CFG_RESET;
      mode_cfg_reg <= `MODE_CFG_RESET;
      class_hi_reg <= `CLASS_HI_RESET;
      user_cfg_reg <= `USER_CFG_RESET;
    end else if (soft_clr) begin
      // soft-reset bit comes back as zero
      if_cfg_reg   <= `IF_CFG_RESET;
      mode_cfg_reg <= `MODE_CFG_RESET;
      class_hi_reg <= `CLASS_HI_RESET;
      user_cfg_reg <= `USER_CFG_RESET;
    end else if (wr_en) begin
      // read-only bits and registers not written
      case (addr_reg)
        `ADDR_IF_CFG:    if_cfg_reg   <= (wr_data & 8'h6f) | 8'h10;
        // mode field incl. reserved codes stored
        `ADDR_MODE_CFG:  mode_cfg_reg <= wr_data;
        `ADDR_DEV_CLASS: class_hi_reg <= wr_data[7:4];
        `ADDR_USER_CFG:  user_cfg_reg <= wr_data;
        default:         ;
      endcase
    end
  end

  // chip reset held for the quiet period
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_cnt_reg <= 7'h00;
      chip_reset  <= 1'b0;
    end else if (soft_clr) begin
      rst_cnt_reg <= RST_CYCLES;
      chip_reset  <= 1'b1;
    end else if (rst_cnt_reg != 7'h00) begin
      rst_cnt_reg <= rst_cnt_reg - 7'h01;
      chip_reset  <= (rst_cnt_reg != 7'h01);
    end
  end

  // mode drives the core power state
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      op_mode    <= `MODE_NORMAL;
      power_down <= 1'b0;
    end else begin
      op_mode    <= mode_cfg_reg[`MODE_MSB:`MODE_LSB];
      power_down <= mode_cfg_reg[`MODE_MSB:`MODE_LSB] == `MODE_POWER_DOWN;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_soft_reset_clear: assert property (soft_clr |=>
    if_cfg_reg == `IF_CFG_RESET && mode_cfg_reg == `MODE_CFG_RESET &&
    class_hi_reg == `CLASS_HI_RESET &&
    user_cfg_reg == `USER_CFG_RESET) else $error("soft reset left state");
  a_reset_hold_len: assert property ($fell(chip_reset) |->
    $past(rst_cnt_reg) == 7'h01 && rst_cnt_reg == 7'h00)
    else $error("chip reset ended early");
  a_self_clear_bit: assert property (soft_clr |=>
    rd_byte(`ADDR_IF_CFG) == `IF_CFG_RESET ##1
    (rd_byte(`ADDR_IF_CFG) & 8'h80) == 8'h00)
    else $error("soft reset bit stuck");
  a_quiet_period: assert property (soft_clr |=>
    (state_reg == spi_cfg_pkg::ST_RST)[*8])
    else $error("frame accepted during reset");
  a_addr_step: assert property (byte_done &&
    !user_cfg_reg[0] && if_cfg_reg[5] && !soft_clr |=>
    addr_reg == $past(addr_reg) + 15'h0001) else $error("bad ascend step");
  a_addr_descend: assert property (byte_done &&
    !user_cfg_reg[0] && !if_cfg_reg[5] && !soft_clr |=>
    addr_reg == $past(addr_reg) - 15'h0001) else $error("bad descend step");
  a_addr_freeze: assert property (byte_done &&
    user_cfg_reg[0] && !soft_clr |=> $stable(addr_reg))
    else $error("frozen address moved");
  a_sep_out_flag: assert property (if_cfg_reg[`IF_SEP_OUT_BIT] &&
    (rd_byte(`ADDR_IF_CFG) & 8'h10) == 8'h10)
    else $error("output-line flag low");
  a_power_down: assert property (mode_cfg_reg[1:0] == 2'h3
    |=> power_down && op_mode == 2'h3) else $error("power down missed");
  a_id_fixed: assert property (
    (rd_byte(`ADDR_DEV_CLASS) & 8'h0f) == {4'h0, DEV_CLASS} &&
    {rd_byte(`ADDR_PART_HI), rd_byte(`ADDR_PART_LO)} == PART_ID)
    else $error("class or part code changed");
  a_maker_fixed: assert property (wr_en |=>
    {rd_byte(`ADDR_MAKER_HI), rd_byte(`ADDR_MAKER_LO)} == MAKER_ID)
    else $error("maker code changed");
  a_ro_ignored: assert property (wr_en && addr_reg == `ADDR_PART_LO
    |=> $stable(if_cfg_reg) && $stable(mode_cfg_reg))
    else $error("read-only write had effect");

  c_soft_reset: cover property (soft_clr ##1 chip_reset);
  c_stream_read: cover property (byte_done && rd_reg ##[1:400] byte_done);
  c_descend_wr: cover property (wr_en && !if_cfg_reg[5]);
  c_freeze: cover property (byte_done && user_cfg_reg[0]);

endmodule : spi_config_id_registers

// >>> spi_host_model.sv
`timescale 1ns/10ps
// behavioural serial host: drives pins just after mclk rise, mode 0
module spi_host_model (
  input  wire logic             mclk,
  output spi_cfg_pkg::spi_in_s  spi_in,
  input  wire logic             sdo,
  input  wire logic             sdo_oe
);
  logic oe_bad;  // a read bit found the output not enabled

  // bus idles deselected with the clock low
  initial begin
    spi_in = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
    oe_bad = 1'b0;
  end

  // one bit: data set while clock low, 5 mclk low then 4 mclk high
  task automatic bit_io(input logic b, input logic rd, output logic s);
    @(posedge mclk);
    spi_in.sdi <= b;
    repeat (4) @(posedge mclk);
    spi_in.sclk <= 1'b1;
    s = sdo;
    if (rd && sdo_oe !== 1'b1) oe_bad = 1'b1;
    repeat (4) @(posedge mclk);
    spi_in.sclk <= 1'b0;
  endtask : bit_io

  // whole frame: direction, 15 address bits, n data bytes msb first
  task automatic xfer(input logic rd, input logic [14:0] adr,
                      input int n, input logic [3:0][7:0] wd,
                      output logic [3:0][7:0] rq);
    logic [15:0] hdr;
    logic        s;
    hdr = {rd, adr};
    rq  = '0;
    @(posedge mclk);
    spi_in.cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) bit_io(hdr[i], 1'b0, s);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(wd[k][i], rd, s);
        rq[k][i] = s;
      end
    end
    repeat (4) @(posedge mclk);
    // released data line must not keep its last value
    spi_in.cs_n <= 1'b1;
    spi_in.sdi  <= ~spi_in.sdi;
    repeat (4) @(posedge mclk);
  endtask : xfer

  task automatic quiet();
    repeat (80) @(posedge mclk);
  endtask : quiet
endmodule : spi_host_model

// >>> tb_spi_config_id_registers.sv
`timescale 1ns/10ps
`include "spi_cfg_defines.svh"
module tb_spi_config_id_registers;
  localparam logic [3:0]  CLASS_V = 4'h6;     // arbitrary value
  localparam logic [15:0] PART_V  = 16'h93c5; // arbitrary value
  localparam logic [15:0] MAKER_V = 16'h2d48; // arbitrary value

  logic                 mclk, nrst, sdo, sdo_oe, chip_reset, power_down;
  logic [1:0]           op_mode;     // mode field copy
  spi_cfg_pkg::spi_in_s spi_in;      // pins from the host model
  logic [3:0][7:0]      rq;          // bytes of the last read
  logic [1:0]           mm;          // mode under test
  int                   err_total, checks, rst_len, i;

  spi_config_id_registers #(
    .DEV_CLASS (CLASS_V),
    .PART_ID   (PART_V),
    .MAKER_ID  (MAKER_V)
  ) u_spi_config_id_registers (
    .mclk       (mclk),
    .nrst       (nrst),
    .spi_in     (spi_in),
    .sdo        (sdo),
    .sdo_oe     (sdo_oe),
    .chip_reset (chip_reset),
    .op_mode    (op_mode),
    .power_down (power_down)
  );

  spi_host_model u_spi_host_model (
    .mclk   (mclk),
    .spi_in (spi_in),
    .sdo    (sdo),
    .sdo_oe (sdo_oe)
  );

  // 100 MHz clock
  always #5 mclk = ~mclk;

  // length of the internal reset pulse in mclk cycles
  always @(posedge mclk) begin
    if (chip_reset === 1'b1) rst_len <= rst_len + 1;
  end

  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // single-byte write frame
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    u_spi_host_model.xfer(1'b0, a, 1, {24'h0, d}, rq);
  endtask : wr

  // read frame of n bytes; host data line carries a pattern
  task automatic rd(input logic [14:0] a, input int n);
    u_spi_host_model.xfer(1'b1, a, n, 32'ha5c3_5a3c, rq);
  endtask : rd

  // verdict and end of run
  task automatic end_sim();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // watchdog: a hang counts as a mismatch
  initial begin
    #500000;
    err_total++;
    end_sim();
  end

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    err_total = 0;
    checks = 0;
    rst_len = 0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    // reset contents and identity fields
    rd(`ADDR_IF_CFG, 1);
    chk(rq[0], 8'h30);
    rd(`ADDR_MODE_CFG, 1);
    chk(rq[0], 8'h00);
    chk(op_mode, 2'h0);
    rd(`ADDR_DEV_CLASS, 1);
    chk(rq[0], {4'h0, CLASS_V});
    rd(`ADDR_PART_LO, 2);
    chk({rq[1], rq[0]}, PART_V);
    rd(`ADDR_MAKER_LO, 2);
    chk({rq[1], rq[0]}, MAKER_V);
    // writes change only writable bits; read-only places keep their values
    wr(`ADDR_IF_CFG, 8'h20);
    rd(`ADDR_IF_CFG, 1);
    chk(rq[0], 8'h30);
    wr(`ADDR_DEV_CLASS, 8'h5f);
    rd(`ADDR_DEV_CLASS, 1);
    chk(rq[0], {4'h5, CLASS_V});
    for (int k = 0; k < 2; k++) begin
      wr(15'(4 + k), ~PART_V[8*k +: 8]);
      wr(15'(12 + k), ~MAKER_V[8*k +: 8]);
    end
    rd(`ADDR_PART_LO, 2);
    chk({rq[1], rq[0]}, PART_V);
    rd(`ADDR_MAKER_LO, 2);
    chk({rq[1], rq[0]}, MAKER_V);
    // every mode code, reserved ones included
    for (int m = 0; m < 4; m++) begin
      mm = 2'(m);
      wr(`ADDR_MODE_CFG, {6'h0, mm});
      chk(op_mode, mm);
      chk(power_down, mm == 2'h3);
      rd(`ADDR_MODE_CFG, 1);
      chk(rq[0], {6'h0, mm});
    end
    // descending stream: high byte first
    wr(`ADDR_IF_CFG, 8'h10);
    rd(`ADDR_PART_HI, 2);
    chk({rq[0], rq[1]}, PART_V);
    // freeze beats the direction bit, for reads and writes
    wr(`ADDR_USER_CFG, 8'h01);
    rd(`ADDR_PART_LO, 3);
    for (int k = 0; k < 3; k++) chk(rq[k], PART_V[7:0]);
    u_spi_host_model.xfer(1'b0, `ADDR_MODE_CFG, 2, 32'h0000_0103, rq);
    chk(op_mode, 2'h1);
    // soft reset: pulse length, then interface, mode and user fields back to reset
    rst_len = 0;
    wr(`ADDR_IF_CFG, 8'h80);
    i = 0;
    while ((chip_reset !== 1'b0 || rst_len == 0) && i < 400) begin
      @(posedge mclk);
      i++;
    end
    // a reset pulse that never ends counts as a mismatch
    if (i == 400) begin
      err_total++;
      end_sim();
    end
    chk(16'(rst_len), 16'(`SOFT_RST_CYCLES));
    chk(op_mode, 2'h0);
    u_spi_host_model.quiet();
    rd(`ADDR_IF_CFG, 1);
    chk(rq[0], 8'h30);
    rd(`ADDR_MODE_CFG, 1);
    chk(rq[0], 8'h00);
    rd(`ADDR_USER_CFG, 1);
    chk(rq[0], 8'h00);
    chk(u_spi_host_model.oe_bad, 1'b0);
    end_sim();
  end
endmodule : tb_spi_config_id_registers
